// *** core/ppc_pkg.sv ***
package ppc_pkg;

   // Register byte addresses on the APB
   localparam logic [7:0] PPC_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] PPC_ADDR_DATA   = 8'h04;
   localparam logic [7:0] PPC_ADDR_INC    = 8'h08;
   localparam logic [7:0] PPC_ADDR_POWER  = 8'h0C;
   localparam logic [7:0] PPC_ADDR_EVENT  = 8'h10;
   localparam logic [7:0] PPC_ADDR_CORE   = 8'h14;

   // Control register fields
   localparam int PPC_CTRL_MIRROR   = 15;
   localparam int PPC_CTRL_SW_HI    = 14;
   localparam int PPC_CTRL_SW_LO    = 13;
   localparam int PPC_CTRL_OUT_ACT  = 12;
   localparam int PPC_CTRL_IN_ACT   = 11;
   localparam int PPC_CTRL_EN_LO    = 5;
   localparam int PPC_CTRL_ST_LO    = 0;
   localparam logic [15:0] PPC_CTRL_RESET   = 16'h0008;
   localparam logic [15:0] PPC_CTRL_WR_MASK = 16'h7BE0;

   // Source index within the five-bit enable and status groups
   localparam int PPC_SRC_SIF  = 4;
   localparam int PPC_SRC_SOE  = 3;
   localparam int PPC_SRC_PW   = 2;
   localparam int PPC_SRC_PR   = 1;
   localparam int PPC_SRC_EXT  = 0;

   // Event register bits (write one to pulse)
   localparam int PPC_EV_SIF_SET  = 0;
   localparam int PPC_EV_SIF_CLR  = 1;
   localparam int PPC_EV_SOE_SET  = 2;
   localparam int PPC_EV_SOE_CLR  = 3;
   localparam int PPC_EV_IRQ_ACC  = 4;
   localparam int PPC_EV_IRQ_RET  = 5;

   // Power register clock gate bit
   localparam int PPC_PWR_CLK_OFF = 5;

   // Shared legacy vector
   localparam logic [3:0] PPC_VEC_SHARED = 4'h1;
   localparam logic [3:0] PPC_VEC_NONE   = 4'h0;

   // Reset value of the input register
   localparam logic [7:0] PPC_DATA_RESET = 8'h00;

   // Active transfer state machine
   typedef enum logic [1:0] {
      PPC_IDLE,
      PPC_RD_STROBE,
      PPC_WR_STROBE
   } ppc_xfer_t;

   // Parallel pins grouped
   typedef struct packed {
      logic [7:0] data;
      logic [2:0] sel;
      logic       in_strobe_n;
      logic       out_strobe_n;
   } ppc_pins_t;

endpackage

// *** core/ppc_port.sv ***
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bits 14:13 set strobe length 1-4 clocks
// - Bit 12 makes output strobe active
// - Bit 11 makes input strobe active
// - Bits 9:5 enable the five sources
// - Core enable overrides cleared port enable
// - Bits 4:0 report pending source status
// - Bit 15 mirrors bit 4
// - Serial bits concern serial unit one only
// - Reset clears all but bit 3
// - Active read returns register, launches fetch
// - Latent reads pipelined, first read stale
// - One input register for all ports
// - Output register separate from input register
// - Power bit 5 freezes the port
// - Passive write completion raises request
// - Passive read completion raises request
// - Ack asserted on accept, dropped on return
// - Input register shadowed across interrupts when bit 11 is set
// - Port-only enables vector to 0x1
// - Data read clears passive-write status
// - Data write clears passive-read status
// - External status clears on return edge
module ppc_port
   import ppc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Parallel bus inputs
   input  wire logic [7:0]  pb_in,
   input  wire logic        in_strobe_n_in,
   input  wire logic        out_strobe_n_in,
   input  wire logic        external_interrupt_line,
   // Parallel bus outputs
   output ppc_pins_t        pins_out,
   output logic             data_oe,
   output logic             in_strobe_oe,
   output logic             out_strobe_oe,
   output logic             sel_oe,
   // Interrupt side
   output logic             irq_req,
   output logic [3:0]       irq_vector,
   output logic             int_ack
);

   logic [15:0] ctrl_q;
   logic [4:0]  status_q;
   logic [4:0]  core_en_q;
   logic        clk_off_q;
   logic [7:0]  in_reg_q;
   logic [7:0]  out_reg_q;
   logic [7:0]  shadow_q;
   logic        shadow_vld_q;
   logic [2:0]  port_q;
   logic [1:0]  cnt_q;
   ppc_xfer_t   state_q;
   logic        in_strb_d1_q;
   logic        out_strb_d1_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   logic        acc;
   logic        wr_acc;
   logic        rd_acc;
   logic        run;
   logic        in_act;
   logic        out_act;
   logic        data_rd;
   logic        data_wr;
   logic        ev_acc;
   logic        ev_ret;
   logic        pw_done;
   logic        pr_done;
   logic [4:0]  pend;

   // Strobe length in clocks minus one
   function automatic logic [1:0] ppc_width(input logic [15:0] c);
      return c[PPC_CTRL_SW_HI:PPC_CTRL_SW_LO];
   endfunction

   // Bus decode; power gate freezes port activity
   assign acc     = psel && penable && !pready_q;
   assign wr_acc  = acc && pwrite;
   assign rd_acc  = acc && !pwrite;
   assign run     = !clk_off_q;
   assign in_act  = ctrl_q[PPC_CTRL_IN_ACT];
   assign out_act = ctrl_q[PPC_CTRL_OUT_ACT];
   assign data_rd = rd_acc && paddr == PPC_ADDR_DATA && run;
   assign data_wr = wr_acc && paddr == PPC_ADDR_DATA && run;
   assign ev_acc  = wr_acc && paddr == PPC_ADDR_EVENT && pwdata[PPC_EV_IRQ_ACC];
   assign ev_ret  = wr_acc && paddr == PPC_ADDR_EVENT && pwdata[PPC_EV_IRQ_RET];

   // Rising edges of passive strobes mark completion
   assign pw_done = run && !in_act && in_strobe_n_in && !in_strb_d1_q;
   assign pr_done = run && !out_act && out_strobe_n_in && !out_strb_d1_q;

   // Pending sources gated by either enable
   assign pend = status_q & (ctrl_q[PPC_CTRL_EN_LO+:5] | core_en_q);

   // Control register, software fields only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= PPC_CTRL_RESET;
      end else if (wr_acc && paddr == PPC_ADDR_CTRL) begin
         ctrl_q <= (ctrl_q & ~PPC_CTRL_WR_MASK)
                 | (pwdata[15:0] & PPC_CTRL_WR_MASK);
      end
   end

   // Core enables and clock gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_en_q <= 5'h00;
         clk_off_q <= 1'b0;
      end else begin
         if (wr_acc && paddr == PPC_ADDR_INC) begin
            core_en_q <= pwdata[4:0];
         end
         if (wr_acc && paddr == PPC_ADDR_POWER) begin
            clk_off_q <= pwdata[PPC_PWR_CLK_OFF];
         end
      end
   end

   // Strobe history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_strb_d1_q  <= 1'b1;
         out_strb_d1_q <= 1'b1;
      end else begin
         in_strb_d1_q  <= in_strobe_n_in;
         out_strb_d1_q <= out_strobe_n_in;
      end
   end

   // Status bits; hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 5'h08;
      end else begin
         // Serial unit one flags only
         if (wr_acc && paddr == PPC_ADDR_EVENT) begin
            if (pwdata[PPC_EV_SIF_SET]) begin
               status_q[PPC_SRC_SIF] <= 1'b1;
            end else if (pwdata[PPC_EV_SIF_CLR]) begin
               status_q[PPC_SRC_SIF] <= 1'b0;
            end
            if (pwdata[PPC_EV_SOE_SET]) begin
               status_q[PPC_SRC_SOE] <= 1'b1;
            end else if (pwdata[PPC_EV_SOE_CLR]) begin
               status_q[PPC_SRC_SOE] <= 1'b0;
            end
         end
         if (pw_done) begin
            status_q[PPC_SRC_PW] <= 1'b1;
         end else if (data_rd || in_act) begin
            status_q[PPC_SRC_PW] <= 1'b0;
         end
         if (pr_done) begin
            status_q[PPC_SRC_PR] <= 1'b1;
         end else if (data_wr || out_act) begin
            status_q[PPC_SRC_PR] <= 1'b0;
         end
         if (external_interrupt_line &&
             (ctrl_q[PPC_CTRL_EN_LO+PPC_SRC_EXT] || core_en_q[PPC_SRC_EXT])) begin
            status_q[PPC_SRC_EXT] <= 1'b1;
         end else if (ev_ret && int_ack) begin
            status_q[PPC_SRC_EXT] <= 1'b0;
         end
      end
   end

   // Interrupt request, vector and acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req    <= 1'b0;
         irq_vector <= PPC_VEC_NONE;
         int_ack    <= 1'b0;
      end else begin
         irq_req <= |pend;
         if ((pend & ~core_en_q) != 5'h00) begin
            irq_vector <= PPC_VEC_SHARED;
         end else if (pend != 5'h00) begin
            irq_vector <= 4'h2 + {1'b0, 3'(ppc_lowest(pend))};
         end else begin
            irq_vector <= PPC_VEC_NONE;
         end
         if (ev_acc && |pend) begin
            int_ack <= 1'b1;
         end else if (ev_ret) begin
            int_ack <= 1'b0;
         end
      end
   end

   // Lowest pending source picks its own vector
   function automatic logic [2:0] ppc_lowest(input logic [4:0] p);
      logic [2:0] idx;
      idx = 3'd4;
      for (int i = 4; i >= 0; i--) begin
         if (p[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Active transfer sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= PPC_IDLE;
         cnt_q   <= 2'b00;
         port_q  <= 3'b000;
      end else if (run) begin
         case (state_q)
            PPC_IDLE: begin
               cnt_q <= ppc_width(ctrl_q);
               if (data_rd && in_act) begin
                  state_q <= PPC_RD_STROBE;
                  port_q  <= paddr[4:2] ^ paddr[4:2];
               end else if (data_wr && out_act) begin
                  state_q <= PPC_WR_STROBE;
               end
               if (acc && paddr == PPC_ADDR_DATA) begin
                  port_q <= pwdata[26:24] & {3{pwrite}} | port_q & {3{!pwrite}};
               end
            end
            PPC_RD_STROBE, PPC_WR_STROBE: begin
               if (cnt_q == 2'b00) begin
                  state_q <= PPC_IDLE;
               end else begin
                  cnt_q <= cnt_q - 2'b01;
               end
            end
            default: state_q <= PPC_IDLE;
         endcase
      end
   end

   // Input register, fetched or written by the far party, shadowed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_reg_q     <= PPC_DATA_RESET;
         shadow_q     <= PPC_DATA_RESET;
         shadow_vld_q <= 1'b0;
      end else begin
         if (ev_acc && |pend && in_act) begin
            shadow_q     <= in_reg_q;
            shadow_vld_q <= 1'b1;
         end else if (!in_act) begin
            shadow_vld_q <= 1'b0;
         end
         if (ev_ret && shadow_vld_q && in_act) begin
            in_reg_q     <= shadow_q;
            shadow_vld_q <= 1'b0;
         end else if (run && in_act && !pins_out.in_strobe_n
                      && state_q != PPC_RD_STROBE) begin
            // Sample on the last low cycle of the driven strobe
            in_reg_q <= pb_in;
         end else if (pw_done) begin
            in_reg_q <= pb_in;
         end
      end
   end

   // Output register, never touches input register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg_q <= PPC_DATA_RESET;
      end else if (data_wr) begin
         out_reg_q <= pwdata[7:0];
      end
   end

   // Pin drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_out      <= '{data: 8'h00, sel: 3'b000,
                            in_strobe_n: 1'b1, out_strobe_n: 1'b1};
         data_oe       <= 1'b0;
         in_strobe_oe  <= 1'b0;
         out_strobe_oe <= 1'b0;
         sel_oe        <= 1'b0;
      end else begin
         pins_out.data <= out_reg_q;
         pins_out.sel  <= port_q;
         pins_out.in_strobe_n  <= !(run && state_q == PPC_RD_STROBE);
         pins_out.out_strobe_n <= !(run && state_q == PPC_WR_STROBE);
         in_strobe_oe  <= in_act;
         out_strobe_oe <= out_act;
         sel_oe        <= in_act && out_act;
         data_oe       <= (state_q == PPC_WR_STROBE)
                        || (!out_act && !out_strobe_n_in);
      end
   end

   // APB read data, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         if (psel && penable && !pready_q) begin
            case (paddr)
               PPC_ADDR_CTRL: prdata_q <= {16'h0000,
                  status_q[PPC_SRC_SIF], ctrl_q[14:5], status_q};
               PPC_ADDR_DATA:  prdata_q <= {24'h000000, in_reg_q};
               PPC_ADDR_INC:   prdata_q <= {27'h0, core_en_q};
               PPC_ADDR_POWER: prdata_q <= {26'h0, clk_off_q, 5'h00};
               PPC_ADDR_EVENT: prdata_q <= 32'h0000_0000;
               PPC_ADDR_CORE:  prdata_q <= {24'h0, int_ack, irq_vector,
                                            2'(state_q), irq_req};
               default:        pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

endmodule

`default_nettype wire

// *** tb/ppc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_checker
   import ppc_pkg::*;
(
   // APB side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Port side
   input wire ppc_pins_t   pins_out,
   input wire logic        in_strobe_oe,
   input wire logic        irq_req,
   input wire logic [3:0]  irq_vector,
   input wire logic        int_ack
);
   logic        wr_done;
   logic        ret_wr;
   logic [15:0] ctl_q;
   logic [2:0]  lo_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed writes
   assign wr_done = psel && penable && pready && pwrite;
   assign ret_wr = wr_done && paddr == PPC_ADDR_EVENT && pwdata[5];
   // Shadow of writable control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl_q <= 16'h0000;
      else if (wr_done && paddr == PPC_ADDR_CTRL)
         ctl_q <= pwdata[15:0] & PPC_CTRL_WR_MASK;
   end
   // Low cycles of the input strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_q <= 3'h0;
      else lo_q <= pins_out.in_strobe_n ? 3'h0 : lo_q + 3'h1;
   end
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_pulse; pready ##1 !pready; endsequence
   sequence s_ctl; pready && !pwrite && paddr == PPC_ADDR_CTRL; endsequence
   a_one_wait: assert property (s_wait |=> s_pulse)
      else $error("pready not after one wait state");
   a_err_unmapped: assert property (pslverr |-> pready && paddr > 8'h14)
      else $error("pslverr on a mapped address");
   a_mirror_bit: assert property (s_ctl |-> prdata[15] == prdata[4])
      else $error("bit 15 differs from bit 4");
   a_ctrl_fields: assert property (s_ctl |->
      (prdata[15:0] & PPC_CTRL_WR_MASK) == ctl_q)
      else $error("control fields differ from writes");
   a_strobe_width: assert property ($rose(pins_out.in_strobe_n) |->
      lo_q == {1'b0, ctl_q[14:13]} + 3'h1)
      else $error("input strobe width wrong");
   a_passive_quiet: assert property (!ctl_q[11] &&
      !$past(ctl_q[11]) |-> !in_strobe_oe)
      else $error("input strobe driven in passive mode");
   a_vector_none: assert property (irq_req == (irq_vector != 4'h0))
      else $error("vector and request disagree");
   a_ack_accept: assert property ($rose(int_ack) |-> $past(irq_req))
      else $error("ack without request");
   a_ack_return: assert property ($fell(int_ack) |-> ret_wr)
      else $error("ack dropped without return");
endmodule
bind ppc_port ppc_checker ppc_checker_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins_out,
   .in_strobe_oe, .irq_req, .irq_vector, .int_ack);
`default_nettype wire

// *** tb/ppc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_host_model
   import ppc_pkg::*;
(
   // Pins from the port
   input  wire logic      pclk,
   input  wire ppc_pins_t pins_out,
   input  wire logic      data_oe,
   input  wire logic      in_strobe_oe,
   input  wire logic      out_strobe_oe,
   // Resolved levels to the port
   output logic [7:0]     pb_in,
   output logic           in_strobe_n_in,
   output logic           out_strobe_n_in
);
   logic [7:0] port_val [8];
   logic [7:0] host_b = 8'h00;
   logic [7:0] float_q = 8'h00;
   logic       hold = 1'b0;
   logic       ids_n = 1'b1;
   logic       ods_n = 1'b1;
   // Released bus changes every cycle
   always @(posedge pclk) float_q <= float_q + 8'h35;
   // Wire levels from all drivers
   always_comb begin
      if (data_oe) pb_in = pins_out.data;
      else if (in_strobe_oe && !pins_out.in_strobe_n)
         pb_in = port_val[pins_out.sel];
      else pb_in = hold ? host_b : float_q;
      in_strobe_n_in = in_strobe_oe ? pins_out.in_strobe_n : ids_n;
      out_strobe_n_in = out_strobe_oe ? pins_out.out_strobe_n : ods_n;
   end
   // Host write, data held past the rising strobe
   task automatic passive_write(input logic [7:0] b);
      @(posedge pclk);
      host_b <= b;
      hold <= 1'b1;
      @(posedge pclk);
      ids_n <= 1'b0;
      repeat (2) @(posedge pclk);
      ids_n <= 1'b1;
      repeat (2) @(posedge pclk);
      hold <= 1'b0;
   endtask
   // Host read strobe
   task automatic passive_read;
      @(posedge pclk);
      ods_n <= 1'b0;
      repeat (2) @(posedge pclk);
      ods_n <= 1'b1;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ppc_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, ext, isn, osn;
   logic        pready, pslverr, data_oe, ioe, ooe, irq_req, int_ack;
   logic [7:0]  paddr, pb_in, in_q, b;
   logic [31:0] pwdata, prdata;
   logic [3:0]  irq_vector;
   logic [2:0]  k;
   ppc_pins_t   pins_out;
   logic [32:0] exp_q [$];
   logic [31:0] msk_q [$];
   int          n_fail = 0;
   int          checks_done = 0;
   always #25 pclk = ~pclk;
   ppc_port ppc_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pb_in, .in_strobe_n_in(isn),
      .out_strobe_n_in(osn), .external_interrupt_line(ext), .pins_out,
      .data_oe, .in_strobe_oe(ioe), .out_strobe_oe(ooe), .sel_oe(),
      .irq_req, .irq_vector, .int_ack);
   ppc_host_model ppc_host_model_i (.pclk, .pins_out, .data_oe,
      .in_strobe_oe(ioe), .out_strobe_oe(ooe), .pb_in,
      .in_strobe_n_in(isn), .out_strobe_n_in(osn));
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Read answers against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
   end
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e, input logic [31:0] m);
      @(posedge pclk);
      if (!w) begin
         exp_q.push_back({e[32], e[31:0] & m});
         msk_q.push_back(m);
      end
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      apb(1'b0, a, {5'h00, k, 24'h000000}, {1'b0, e}, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 32'h0);
   endtask
   task automatic idle;
      repeat (2) @(posedge pclk);
      while (!(pins_out.in_strobe_n && pins_out.out_strobe_n))
         @(posedge pclk);
   endtask
   // Watchdog
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      end_of_test;
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, ext, paddr, pwdata, k} = '0;
      in_q = PPC_DATA_RESET;
      void'($urandom(32'h8a5bd33d));
      for (int j = 0; j < 8; j++) ppc_host_model_i.port_val[j] = 8'($urandom);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(PPC_ADDR_CTRL, 32'h8, 32'hFFFF);
      apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0}, 32'h0);
      wr(PPC_ADDR_CTRL, 32'hFFFF);
      rd(PPC_ADDR_CTRL, 32'h7BE8, 32'hFFFF);
      rd(PPC_ADDR_CORE, 32'h09, 32'h79);
      wr(PPC_ADDR_EVENT, 32'h01);
      rd(PPC_ADDR_CTRL, 32'hFBF8, 32'hFFFF);
      wr(PPC_ADDR_EVENT, 32'h0A);
      rd(PPC_ADDR_CORE, 32'h00, 32'h79);
      for (int w = 0; w < 4; w++) begin
         wr(PPC_ADDR_CTRL, 32'(w << 13) | 32'h1800);
         repeat (2) begin
            k = 3'($urandom);
            wr(PPC_ADDR_DATA, {5'h00, k, 16'h0, 8'h5A});
            idle;
            rd(PPC_ADDR_DATA, {24'h0, in_q}, 32'hFF);
            in_q = ppc_host_model_i.port_val[k];
            idle;
         end
      end
      wr(PPC_ADDR_CTRL, 32'h0);
      ext <= 1'b1;
      wr(PPC_ADDR_INC, 32'h0);
      rd(PPC_ADDR_CTRL, 32'h0, 32'hFFFF);
      ext <= 1'b0;
      wr(PPC_ADDR_CTRL, 32'hE0);
      ext <= 1'b1;
      wr(PPC_ADDR_INC, 32'h0);
      ext <= 1'b0;
      rd(PPC_ADDR_CTRL, 32'hE1, 32'hFFFF);
      wr(PPC_ADDR_EVENT, 32'h10);
      rd(PPC_ADDR_CORE, 32'h89, 32'hF9);
      wr(PPC_ADDR_EVENT, 32'h20);
      rd(PPC_ADDR_CTRL, 32'hE0, 32'hFFFF);
      b = 8'($urandom);
      ppc_host_model_i.passive_write(b);
      rd(PPC_ADDR_CTRL, 32'hE4, 32'hFFFF);
      rd(PPC_ADDR_DATA, {24'h0, b}, 32'hFF);
      rd(PPC_ADDR_CTRL, 32'hE0, 32'hFFFF);
      ppc_host_model_i.passive_read;
      rd(PPC_ADDR_CTRL, 32'hE2, 32'hFFFF);
      wr(PPC_ADDR_DATA, 32'h11);
      rd(PPC_ADDR_CTRL, 32'hE0, 32'hFFFF);
      wr(PPC_ADDR_CTRL, 32'h0);
      ppc_host_model_i.passive_write(b);
      rd(PPC_ADDR_CORE, 32'h00, 32'h79);
      wr(PPC_ADDR_INC, 32'h04);
      rd(PPC_ADDR_CORE, 32'h21, 32'h79);
      end_of_test;
   end
endmodule
`default_nettype wire
